// [inc/tct_map.vh]
// register map, field layout and encodings of the translation cache tagging block
// ==========================================================================
`ifndef TCT_MAP_VH
`define TCT_MAP_VH
// ==========================================================================
// register offsets
`define TCT_REG_CTRL      8'h00
`define TCT_REG_VP_TAG    8'h04
`define TCT_REG_ROOT_LO   8'h08
`define TCT_REG_ROOT_HI   8'h0C
`define TCT_REG_INV_TAG   8'h10
`define TCT_REG_INV_PAGE  8'h14
`define TCT_REG_INV_RT_LO 8'h18
`define TCT_REG_INV_RT_HI 8'h1C
`define TCT_REG_INV_CMD   8'h20
`define TCT_REG_STATUS    8'h24
// ==========================================================================
// fields
`define TCT_CTRL_SL_BIT   0
`define TCT_CMD_CLASS_BIT 8
`define TCT_ST_READY_BIT  0
`define TCT_ST_BAD_BIT    1
`define TCT_ST_DONE_BIT   2
`define TCT_CTRL_RST      1'h0
`define TCT_TAG_RST       16'h0000
`define TCT_ROOT_RST      40'h00_0000_0000
// ==========================================================================
// mapping kinds and command types
`define TCT_KIND_LIN      2'h0
`define TCT_KIND_COMB     2'h1
`define TCT_KIND_GP       2'h2
`define TCT_TI_ADDR       4'h0
`define TCT_TI_SINGLE     4'h1
`define TCT_TI_ALL        4'h2
`define TCT_TI_KEEP_GLOB  4'h3
`define TCT_SI_SINGLE     4'h1
`define TCT_SI_ALL        4'h2
`endif

// [verilog/tct_inv_decode.v]
// decoder of invalidation command class and type into kill controls
`timescale 1ns/1ps
`include "tct_map.vh"
module tct_inv_decode (
  // command
  input  wire       go,
  input  wire       sl_class,
  input  wire [3:0] cmd_type,
  // kill controls
  output reg        kill_lin,
  output reg        kill_gp,
  output reg        use_tag,
  output reg        use_page,
  output reg        keep_glob,
  output reg        spare_tag0,
  output reg        use_root,
  output reg        bad
);
  always @* begin
    kill_lin   = 1'b0;
    kill_gp    = 1'b0;
    use_tag    = 1'b0;
    use_page   = 1'b0;
    keep_glob  = 1'b0;
    spare_tag0 = 1'b0;
    use_root   = 1'b0;
    bad        = 1'b0;
    if (go && !sl_class) begin
      case (cmd_type)
        `TCT_TI_ADDR: begin
          kill_lin = 1'b1;
          use_tag  = 1'b1;
          use_page = 1'b1;
        end
        `TCT_TI_SINGLE: begin
          kill_lin = 1'b1;
          use_tag  = 1'b1;
        end
        `TCT_TI_ALL: begin
          kill_lin   = 1'b1;
          spare_tag0 = 1'b1;
        end
        `TCT_TI_KEEP_GLOB: begin
          kill_lin  = 1'b1;
          use_tag   = 1'b1;
          keep_glob = 1'b1;
        end
        default: bad = 1'b1;
      endcase
    end else if (go) begin
      case (cmd_type)
        `TCT_SI_SINGLE: begin
          kill_gp  = 1'b1;
          use_root = 1'b1;
        end
        `TCT_SI_ALL: kill_gp = 1'b1;
        default: bad = 1'b1;
      endcase
    end
  end
endmodule // tct_inv_decode

// [verilog/tct_entry.v]
// one cached mapping with its tags, lookup match and kill logic
`timescale 1ns/1ps
`include "tct_map.vh"
module tct_entry #(
  parameter TAG_W  = 16,
  parameter ROOT_W = 40,
  parameter PAGE_W = 36,
  parameter FRM_W  = 40
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // fill
  input  wire              wr,
  input  wire [1:0]        wr_kind,
  input  wire              wr_glob,
  input  wire [TAG_W-1:0]  wr_tag,
  input  wire [ROOT_W-1:0] wr_root,
  input  wire [PAGE_W-1:0] wr_page,
  input  wire [FRM_W-1:0]  wr_frame,
  // query and violation kill
  input  wire [1:0]        q_kind,
  input  wire [TAG_W-1:0]  q_tag,
  input  wire [ROOT_W-1:0] q_root,
  input  wire [PAGE_W-1:0] q_page,
  input  wire              q_kill,
  output wire              q_hit,
  output wire [FRM_W-1:0]  frame_out,
  // command kill
  input  wire              kill_lin,
  input  wire              kill_gp,
  input  wire              use_tag,
  input  wire              use_page,
  input  wire              keep_glob,
  input  wire              spare_tag0,
  input  wire              use_root,
  input  wire [TAG_W-1:0]  i_tag,
  input  wire [PAGE_W-1:0] i_page,
  input  wire [ROOT_W-1:0] i_root
);
  reg              valid;
  reg [1:0]        kind;
  reg              glob;
  reg [TAG_W-1:0]  tag;
  reg [ROOT_W-1:0] root;
  reg [PAGE_W-1:0] page;
  reg [FRM_W-1:0]  frame;
  wire lin_side = (kind != `TCT_KIND_GP);
  wire gp_side  = (kind != `TCT_KIND_LIN);
  // globals match any tag only in the lookup; commands still name the tag
  assign q_hit = valid && (kind == q_kind) && (page == q_page) &&
                 (!lin_side || glob || tag == q_tag) &&
                 (!gp_side || root == q_root);
  assign frame_out = frame;
  wire t_kill = kill_lin && lin_side && (!use_tag || tag == i_tag) &&
                (!use_page || page == i_page) && !(keep_glob && glob) &&
                !(spare_tag0 && tag == {TAG_W{1'b0}});
  wire s_kill = kill_gp && gp_side && (!use_root || root == i_root);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      kind  <= `TCT_KIND_LIN;
      glob  <= 1'b0;
      tag   <= {TAG_W{1'b0}};
      root  <= {ROOT_W{1'b0}};
      page  <= {PAGE_W{1'b0}};
      frame <= {FRM_W{1'b0}};
    end else if (wr) begin
      valid <= 1'b1;
      kind  <= wr_kind;
      glob  <= wr_glob;
      tag   <= wr_tag;
      root  <= wr_root;
      page  <= wr_page;
      frame <= wr_frame;
    end else if (t_kill || s_kill || (q_kill && q_hit)) begin
      valid <= 1'b0;
    end
  end
endmodule // tct_entry

// [verilog/tct_cache.v]
// translation cache with processor-tag and root-pointer tagging and invalidation
`timescale 1ns/1ps
`include "tct_map.vh"
module tct_cache #(
  parameter ENTRIES = 8,
  parameter PTR_W   = 3,
  parameter TAG_W   = 16,
  parameter ROOT_W  = 40,
  parameter PAGE_W  = 36,
  parameter FRM_W   = 40
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // register port
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // lookup
  input  wire              lk_req,
  input  wire              lk_gpa,
  input  wire [PAGE_W-1:0] lk_page,
  output reg               lk_done,
  output reg               lk_hit,
  output reg  [FRM_W-1:0]  lk_frame,
  // fill from the table walker
  input  wire              fill_valid,
  input  wire              fill_gpa,
  input  wire              fill_global,
  input  wire              fill_present,
  input  wire              fill_misconfig,
  input  wire [PAGE_W-1:0] fill_page,
  input  wire [FRM_W-1:0]  fill_frame,
  // second-level violation of the current access
  input  wire              viol,
  input  wire              viol_gpa,
  input  wire [PAGE_W-1:0] viol_page,
  // state
  output reg               ready,
  output reg               inv_done
);
  // ========================================================================
  // software registers
  reg              sl_en;
  reg [TAG_W-1:0]  vp_tag;
  reg [ROOT_W-1:0] root_ptr;
  reg [TAG_W-1:0]  inv_tag;
  reg [PAGE_W-1:0] inv_page;
  reg [ROOT_W-1:0] inv_root;
  reg              cmd_go;
  reg              cmd_sl;
  reg [3:0]        cmd_type;
  reg              bad_flag;
  wire             dec_bad;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sl_en    <= `TCT_CTRL_RST;
      vp_tag   <= `TCT_TAG_RST;
      root_ptr <= `TCT_ROOT_RST;
      inv_tag  <= `TCT_TAG_RST;
      inv_page <= {PAGE_W{1'b0}};
      inv_root <= `TCT_ROOT_RST;
      cmd_go   <= 1'b0;
      cmd_sl   <= 1'b0;
      cmd_type <= 4'h0;
    end else begin
      cmd_go <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `TCT_REG_CTRL:      sl_en <= reg_wdata[`TCT_CTRL_SL_BIT];
          `TCT_REG_VP_TAG:    vp_tag <= reg_wdata[TAG_W-1:0];
          `TCT_REG_ROOT_LO:   root_ptr[19:0] <= reg_wdata[31:12];
          `TCT_REG_ROOT_HI:   root_ptr[ROOT_W-1:20] <= reg_wdata[ROOT_W-21:0];
          `TCT_REG_INV_TAG:   inv_tag <= reg_wdata[TAG_W-1:0];
          `TCT_REG_INV_PAGE:  inv_page <= {{(PAGE_W-32){1'b0}}, reg_wdata};
          `TCT_REG_INV_RT_LO: inv_root[19:0] <= reg_wdata[31:12];
          `TCT_REG_INV_RT_HI: inv_root[ROOT_W-1:20] <= reg_wdata[ROOT_W-21:0];
          `TCT_REG_INV_CMD: begin
            cmd_go   <= ready;
            cmd_sl   <= reg_wdata[`TCT_CMD_CLASS_BIT];
            cmd_type <= reg_wdata[3:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ========================================================================
  // status: sticky bad-command flag, write one to clear, a new bad command wins
  wire bad_clr = reg_wr && (reg_addr == `TCT_REG_STATUS) && reg_wdata[`TCT_ST_BAD_BIT];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_flag <= 1'b0;
      inv_done <= 1'b0;
      ready    <= 1'b0;
    end else begin
      ready    <= 1'b1;
      inv_done <= cmd_go && !dec_bad;
      if (cmd_go && dec_bad)
        bad_flag <= 1'b1;
      else if (bad_clr)
        bad_flag <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `TCT_REG_CTRL:      reg_rdata <= {31'h0000_0000, sl_en};
        `TCT_REG_VP_TAG:    reg_rdata <= {{(32-TAG_W){1'b0}}, vp_tag};
        `TCT_REG_ROOT_LO:   reg_rdata <= {root_ptr[19:0], 12'h000};
        `TCT_REG_ROOT_HI:   reg_rdata <= {12'h000, root_ptr[ROOT_W-1:20]};
        `TCT_REG_INV_TAG:   reg_rdata <= {{(32-TAG_W){1'b0}}, inv_tag};
        `TCT_REG_INV_PAGE:  reg_rdata <= inv_page[31:0];
        `TCT_REG_INV_RT_LO: reg_rdata <= {inv_root[19:0], 12'h000};
        `TCT_REG_INV_RT_HI: reg_rdata <= {12'h000, inv_root[ROOT_W-1:20]};
        `TCT_REG_INV_CMD:   reg_rdata <= {23'h00_0000, cmd_sl, 4'h0, cmd_type};
        `TCT_REG_STATUS:    reg_rdata <= {29'h0000_0000, inv_done, bad_flag, ready};
        default:            reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ========================================================================
  // command decode
  wire d_kill_lin;
  wire d_kill_gp;
  wire d_use_tag;
  wire d_use_page;
  wire d_keep_glob;
  wire d_spare_tag0;
  wire d_use_root;

  tct_inv_decode u_dec (
    .go         (cmd_go),
    .sl_class   (cmd_sl),
    .cmd_type   (cmd_type),
    .kill_lin   (d_kill_lin),
    .kill_gp    (d_kill_gp),
    .use_tag    (d_use_tag),
    .use_page   (d_use_page),
    .keep_glob  (d_keep_glob),
    .spare_tag0 (d_spare_tag0),
    .use_root   (d_use_root),
    .bad        (dec_bad)
  );

  // ========================================================================
  // context of the current access: kind follows the translation mode
  function [1:0] ctx_kind;
    input sl;
    input gpa;
    begin
      if (gpa)
        ctx_kind = `TCT_KIND_GP;
      else if (sl)
        ctx_kind = `TCT_KIND_COMB;
      else
        ctx_kind = `TCT_KIND_LIN;
    end
  endfunction

  // a violation borrows the query path; a lookup in that cycle answers miss
  wire [1:0]        q_kind = viol ? ctx_kind(sl_en, viol_gpa) : ctx_kind(sl_en, lk_gpa);
  wire [PAGE_W-1:0] q_page = viol ? viol_page : lk_page;

  // fills never keep what came from absent or misconfigured entries
  wire fill_ok = ready && fill_valid && fill_present && !fill_misconfig;
  wire [1:0] f_kind = ctx_kind(sl_en, fill_gpa);
  wire [ROOT_W-1:0] f_root = sl_en ? root_ptr : {ROOT_W{1'b0}};
  wire f_glob = fill_global && !fill_gpa;

  // round-robin victim; simple, and no entry lives forever
  reg [PTR_W-1:0] victim;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      victim <= {PTR_W{1'b0}};
    else if (fill_ok)
      victim <= (victim == ENTRIES - 1) ? {PTR_W{1'b0}} : victim + 1'b1;
  end

  // ========================================================================
  // entries
  wire [ENTRIES-1:0]       hit_vec;
  wire [ENTRIES*FRM_W-1:0] frm_flat;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
      tct_entry #(
        .TAG_W  (TAG_W),
        .ROOT_W (ROOT_W),
        .PAGE_W (PAGE_W),
        .FRM_W  (FRM_W)
      ) u_ent (
        .clk        (clk),
        .rst_n      (rst_n),
        .wr         (fill_ok && (victim == g)),
        .wr_kind    (f_kind),
        .wr_glob    (f_glob),
        .wr_tag     (vp_tag),
        .wr_root    (f_root),
        .wr_page    (fill_page),
        .wr_frame   (fill_frame),
        .q_kind     (q_kind),
        .q_tag      (vp_tag),
        .q_root     (root_ptr),
        .q_page     (q_page),
        .q_kill     (viol),
        .q_hit      (hit_vec[g]),
        .frame_out  (frm_flat[g*FRM_W +: FRM_W]),
        .kill_lin   (d_kill_lin),
        .kill_gp    (d_kill_gp),
        .use_tag    (d_use_tag),
        .use_page   (d_use_page),
        .keep_glob  (d_keep_glob),
        .spare_tag0 (d_spare_tag0),
        .use_root   (d_use_root),
        .i_tag      (inv_tag),
        .i_page     (inv_page),
        .i_root     (inv_root)
      );
    end
  endgenerate

  // ========================================================================
  // lookup answer, one cycle after the request
  reg [FRM_W-1:0] next_frame;
  integer i;
  always @* begin
    next_frame = {FRM_W{1'b0}};
    for (i = 0; i < ENTRIES; i = i + 1) begin
      if (hit_vec[i])
        next_frame = next_frame | frm_flat[i*FRM_W +: FRM_W];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_done  <= 1'b0;
      lk_hit   <= 1'b0;
      lk_frame <= {FRM_W{1'b0}};
    end else begin
      lk_done  <= lk_req && ready;
      lk_hit   <= lk_req && ready && !viol && (|hit_vec);
      lk_frame <= (lk_req && ready && !viol) ? next_frame : {FRM_W{1'b0}};
    end
  end
endmodule // tct_cache

// [tb/tct_cache_properties.sv]
// concurrent checks on the translation cache ports
`timescale 1ns/1ps
`include "tct_map.vh"
module tct_cache_properties #(
  parameter FRM_W = 40
) (
  // clock and reset
  input wire             clk,
  input wire             rst_n,
  // register port
  input wire [7:0]       reg_addr,
  input wire [31:0]      reg_wdata,
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [31:0]      reg_rdata,
  // lookup and state
  input wire             lk_req,
  input wire             viol,
  input wire             lk_done,
  input wire             lk_hit,
  input wire [FRM_W-1:0] lk_frame,
  input wire             ready,
  input wire             inv_done
);
  // ==========================================================
  // properties
  wire cmd = reg_wr && ready && (reg_addr == `TCT_REG_INV_CMD);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ready; !ready |=> ready; endproperty
  a_ready: assert property (p_ready)
    else $error("ready late after reset");
  property p_lk_ans; lk_req && ready |=> lk_done; endproperty
  a_lk_ans: assert property (p_lk_ans)
    else $error("lookup not answered");
  property p_lk_idle; !(lk_req && ready) |=> !lk_done; endproperty
  a_lk_idle: assert property (p_lk_idle)
    else $error("answer without taken lookup");
  property p_miss; lk_done && !lk_hit |-> lk_frame == '0; endproperty
  a_miss: assert property (p_miss)
    else $error("frame not zero on miss");
  property p_viol; lk_req && ready && viol |=> lk_done && !lk_hit; endproperty
  a_viol: assert property (p_viol)
    else $error("hit beside a violation");
  property p_unmap; reg_rd && reg_addr == 8'h28 |=> reg_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_tag_done;
    cmd && !reg_wdata[8] && reg_wdata[3:0] <= 4'h3 |=> ##1 inv_done;
  endproperty
  a_tag_done: assert property (p_tag_done)
    else $error("tag command not completed");
  property p_sl_done;
    cmd && reg_wdata[8] && (reg_wdata[3:0] == 4'h1 || reg_wdata[3:0] == 4'h2)
      |=> ##1 inv_done;
  endproperty
  a_sl_done: assert property (p_sl_done)
    else $error("root command not completed");
  property p_bad; cmd && !reg_wdata[8] && reg_wdata[3:0] > 4'h3 |-> ##2 !inv_done; endproperty
  a_bad: assert property (p_bad)
    else $error("undefined command completed");
endmodule // tct_cache_properties

// [tb/tct_hv_model.sv]
// hypervisor software model driving the register port
`timescale 1ns/1ps
`include "tct_map.vh"
module tct_hv_model (
  // clock
  input  wire        clk,
  // register port
  output reg  [7:0]  reg_addr,
  output reg  [31:0] reg_wdata,
  output reg         reg_wr,
  output reg         reg_rd,
  input  wire [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // released data never keeps the old value
      reg_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
    end
  endtask
  // root bits 51:12 split over a low and high register
  task pair(input [7:0] a, input [39:0] r);
    begin
      wr(a, {r[19:0], 12'h000});
      wr(a + 8'h04, {12'h000, r[39:20]});
    end
  endtask
  task tinv(input [3:0] t, input [15:0] tag, input [35:0] pg);
    begin
      wr(`TCT_REG_INV_TAG, {16'h0000, tag});
      wr(`TCT_REG_INV_PAGE, pg[31:0]);
      wr(`TCT_REG_INV_CMD, {23'h000000, 1'b0, 4'h0, t}); // class 0
    end
  endtask
  task sinv(input [3:0] t, input [39:0] r);
    begin
      pair(`TCT_REG_INV_RT_LO, r); // root naming the entries
      wr(`TCT_REG_INV_CMD, {23'h000000, 1'b1, 4'h0, t});
    end
  endtask
endmodule // tct_hv_model

// [tb/tb_top.sv]
// top testbench of the translation cache
`timescale 1ns/1ps
`include "tct_map.vh"
module tb_top;
  // ==========================================================
  // signals
  reg         clk, rst_n, lk_req, lk_gpa, viol, viol_gpa;
  reg         fill_valid, fill_gpa, fill_global, fill_present, fill_misconfig;
  reg  [35:0] lk_page, fill_page, viol_page;
  reg  [39:0] fill_frame;
  wire [7:0]  reg_addr;
  wire [31:0] reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, lk_done, lk_hit, ready, inv_done;
  wire [39:0] lk_frame;
  reg  [31:0] d;
  integer     err_count, check_count;
  tct_hv_model u_hv (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tct_cache u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lk_req(lk_req),
    .lk_gpa(lk_gpa), .lk_page(lk_page), .lk_done(lk_done), .lk_hit(lk_hit),
    .lk_frame(lk_frame), .fill_valid(fill_valid), .fill_gpa(fill_gpa),
    .fill_global(fill_global), .fill_present(fill_present),
    .fill_misconfig(fill_misconfig), .fill_page(fill_page), .fill_frame(fill_frame),
    .viol(viol), .viol_gpa(viol_gpa), .viol_page(viol_page), .ready(ready),
    .inv_done(inv_done));
  // ==========================================================
  // tasks
  task complete_run;
    begin
      if (err_count == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task fill(input g, input glob, input pres, input mis, input [35:0] pg);
    begin
      @(posedge clk);
      fill_valid <= 1'b1;
      fill_gpa <= g;
      fill_global <= glob;
      fill_present <= pres;
      fill_misconfig <= mis;
      fill_page <= pg;
      fill_frame <= {4'hC, pg};
      @(posedge clk);
      fill_valid <= 1'b0;
    end
  endtask
  // lookup, optionally beside a violation on the same page
  task lk(input g, input [35:0] pg, input h, input v);
    begin
      @(posedge clk);
      lk_req <= 1'b1;
      lk_gpa <= g;
      lk_page <= pg;
      viol <= v;
      viol_gpa <= g;
      viol_page <= pg;
      @(posedge clk);
      lk_req <= 1'b0;
      viol <= 1'b0;
      #1;
      chk({lk_done, lk_hit, lk_frame}, {1'b1, h, h ? {4'hC, pg} : 40'h0});
    end
  endtask
  // ==========================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    err_count = 0;
    check_count = 0;
    {rst_n, lk_req, lk_gpa, viol, viol_gpa, fill_valid, fill_gpa} = 7'h00;
    {fill_global, fill_present, fill_misconfig} = 3'h0;
    {lk_page, fill_page, viol_page, fill_frame} = 148'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    u_hv.rd(`TCT_REG_STATUS, d);
    chk(d, 32'h1); // ready status
    u_hv.rd(8'h28, d);
    chk(d, 32'h0); // unmapped read
    u_hv.tinv(`TCT_TI_ALL, 16'h0000, 36'h0); // session start
    u_hv.sinv(`TCT_SI_ALL, 40'h0); // session start
    u_hv.wr(`TCT_REG_VP_TAG, 32'h5);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h100);
    lk(1'b0, 36'h100, 1'b1, 1'b0); // own tag hits
    u_hv.wr(`TCT_REG_VP_TAG, 32'h6);
    lk(1'b0, 36'h100, 1'b0, 1'b0); // other guest misses
    u_hv.wr(`TCT_REG_VP_TAG, 32'h5);
    u_hv.wr(`TCT_REG_CTRL, 32'h1);
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h12345);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h200);
    fill(1'b1, 1'b0, 1'b1, 1'b0, 36'h300);
    u_hv.wr(`TCT_REG_ROOT_LO, 32'h1234_5FFF);
    lk(1'b0, 36'h200, 1'b1, 1'b0); // low root bits ignored
    lk(1'b1, 36'h300, 1'b1, 1'b0);
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h54321);
    lk(1'b0, 36'h200, 1'b0, 1'b0); // other root misses
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h12345);
    fill(1'b1, 1'b0, 1'b0, 1'b0, 36'h400);
    fill(1'b1, 1'b0, 1'b1, 1'b1, 36'h401);
    lk(1'b1, 36'h400, 1'b0, 1'b0); // absent not cached
    lk(1'b1, 36'h401, 1'b0, 1'b0); // misconfigured not cached
    lk(1'b1, 36'h300, 1'b0, 1'b1); // refused beside violation
    lk(1'b1, 36'h300, 1'b0, 1'b0); // dropped by violation
    u_hv.wr(`TCT_REG_CTRL, 32'h0);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h501);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h502);
    fill(1'b0, 1'b1, 1'b1, 1'b0, 36'h503);
    u_hv.wr(`TCT_REG_VP_TAG, 32'h7);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h504);
    u_hv.wr(`TCT_REG_VP_TAG, 32'h0);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h505);
    u_hv.wr(`TCT_REG_VP_TAG, 32'h5);
    u_hv.tinv(4'h4, 16'h0005, 36'h501);
    u_hv.rd(`TCT_REG_STATUS, d);
    chk(d[1], 1'b1); // bad command flagged
    lk(1'b0, 36'h501, 1'b1, 1'b0); // nothing dropped
    u_hv.wr(`TCT_REG_STATUS, 32'h2); // write one clears the flag
    u_hv.rd(`TCT_REG_STATUS, d);
    chk(d, 32'h1); // bad flag cleared
    u_hv.tinv(`TCT_TI_ADDR, 16'h0005, 36'h501);
    lk(1'b0, 36'h501, 1'b0, 1'b0); // page dropped
    lk(1'b0, 36'h502, 1'b1, 1'b0); // other page kept
    u_hv.tinv(`TCT_TI_KEEP_GLOB, 16'h0005, 36'h0);
    lk(1'b0, 36'h502, 1'b0, 1'b0);
    lk(1'b0, 36'h503, 1'b1, 1'b0); // global spared
    u_hv.tinv(`TCT_TI_SINGLE, 16'h0005, 36'h0); // single-context tag flush
    lk(1'b0, 36'h503, 1'b0, 1'b0); // global dropped too
    u_hv.wr(`TCT_REG_VP_TAG, 32'h7);
    u_hv.tinv(`TCT_TI_ALL, 16'h0000, 36'h0);
    lk(1'b0, 36'h504, 1'b0, 1'b0);
    u_hv.wr(`TCT_REG_VP_TAG, 32'h0);
    lk(1'b0, 36'h505, 1'b1, 1'b0); // tag zero spared
    u_hv.wr(`TCT_REG_CTRL, 32'h1);
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h11111);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h601);
    fill(1'b1, 1'b0, 1'b1, 1'b0, 36'h602);
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h22222);
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h603);
    u_hv.sinv(`TCT_SI_SINGLE, 40'h11111);
    lk(1'b0, 36'h603, 1'b1, 1'b0); // other root kept
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h11111);
    lk(1'b0, 36'h601, 1'b0, 1'b0);
    lk(1'b1, 36'h602, 1'b0, 1'b0);
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h22222);
    u_hv.sinv(4'h3, 40'h22222);
    u_hv.rd(`TCT_REG_STATUS, d);
    chk(d[1], 1'b1); // undefined root type flagged
    lk(1'b0, 36'h603, 1'b1, 1'b0); // undefined root type
    u_hv.sinv(`TCT_SI_ALL, 40'h0);
    lk(1'b0, 36'h603, 1'b0, 1'b0); // every root dropped
    fill(1'b0, 1'b0, 1'b1, 1'b0, 36'h700);
    lk(1'b0, 36'h700, 1'b1, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    u_hv.rd(`TCT_REG_CTRL, d);
    chk(d, 32'h0); // control reset
    u_hv.rd(`TCT_REG_VP_TAG, d);
    chk(d, 32'h0); // tag reset
    u_hv.wr(`TCT_REG_CTRL, 32'h1);
    u_hv.pair(`TCT_REG_ROOT_LO, 40'h22222);
    lk(1'b0, 36'h700, 1'b0, 1'b0); // cleared by reset
    complete_run;
  end
endmodule // tb_top
bind tct_cache tct_cache_properties #(.FRM_W(FRM_W)) u_props (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .lk_req(lk_req), .viol(viol), .lk_done(lk_done),
  .lk_hit(lk_hit), .lk_frame(lk_frame), .ready(ready), .inv_done(inv_done));
